// *** hdl/urp_pkg.sv ***
// Package for the root port status/control block: offsets, fields, resets, timing.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
package urp_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 125_000_000;  // System clock rate
  localparam int unsigned RESET_SIG_MS    = 10;           // Port reset signalling time
  localparam int unsigned RESET_SIG_CYC   = (CLK_HZ / 1000) * RESET_SIG_MS;
  localparam int unsigned RESUME_MS       = 20;           // Resume drive time
  localparam int unsigned RESUME_CYC      = (CLK_HZ / 1000) * RESUME_MS;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [3:0] OFS_PORT = 4'h0;  // Port status/control word
  localparam logic [3:0] OFS_IST  = 4'h4;  // Interrupt status, write one to clear
  localparam logic [3:0] OFS_IMSK = 4'h8;  // Interrupt mask
  localparam logic [3:0] OFS_CFG  = 4'hC;  // Configuration

  // ==========================================================================
  // Port word field positions
  // ==========================================================================
  localparam int unsigned B_CONN  = 0;   // Connected / clear enable
  localparam int unsigned B_ENA   = 1;   // Enabled / set enable
  localparam int unsigned B_SUSP  = 2;   // Suspended / set suspend
  localparam int unsigned B_OVC   = 3;   // Overcurrent / start resume
  localparam int unsigned B_RST   = 4;   // Reset active / start reset
  localparam int unsigned B_PWR   = 8;   // Power on / set power
  localparam int unsigned B_LS    = 9;   // Low speed / clear power
  localparam int unsigned B_CCHG  = 16;  // Connect change
  localparam int unsigned B_ECHG  = 17;  // Enable change
  localparam int unsigned B_SCHG  = 18;  // Resume complete change
  localparam int unsigned B_OCHG  = 19;  // Overcurrent change
  localparam int unsigned B_RCHG  = 20;  // Reset complete change

  // Configuration fields
  localparam int unsigned C_PSW   = 0;   // Power switching supported
  localparam int unsigned C_POC   = 1;   // Per-port overcurrent reporting
  localparam int unsigned C_NRM   = 2;   // Device non-removable
  localparam int unsigned C_URES  = 3;   // Controller enters resume state (pulse)

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [4:0] RST_IMSK = 5'h00;  // All change interrupts masked
  localparam logic [2:0] RST_CFG  = 3'h3;   // Switching and per-port OC on
  localparam logic [1:0] AV_OKAY  = 2'h0;   // Avalon response okay
  localparam logic [1:0] AV_DECE  = 2'h3;   // Avalon decode error

  // Synchronised line inputs
  typedef struct packed {
    logic conn;  // Device attached
    logic ls;    // Low speed device
    logic ovc;   // Overcurrent
    logic bab;   // Bus error such as babble
  } urp_line_s;

  // Port state machine
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_RESET  = 4'b0010,
    ST_SUSP   = 4'b0100,
    ST_RESUME = 4'b1000
  } urp_state_e;

endpackage : urp_pkg

// *** hdl/urp_sync.sv ***
// Two-flop synchroniser for the port's line inputs.
// Assumes inputs are static across several clocks; the first stage feeds only the second.
`timescale 1ns/10ps
module urp_sync
  import urp_pkg::*;
#(
  parameter int unsigned W = 4  // Number of lines
)
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Lines
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);

  // A zero-width line bundle cannot be served
  if (W < 1)
  begin : g_bad_width
    $error("urp_sync: width must be at least one");
  end

  // ==========================================================================
  // Stages
  // ==========================================================================
  logic [W-1:0] meta_ff;  // First stage, read only by second
  logic [W-1:0] sync_ff;  // Second stage

  // Register both stages
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign d_out = sync_ff;

endmodule : urp_sync

// *** hdl/urp_port.sv ***
// Root port status/control block: one port word, change flags and interrupt.
// Assumes an Avalon-MM master; line inputs arrive from the PHY side.
//
// Behaviour
// R01 - Power loss clears connect, enable, suspend, reset
// R02 - Without power switching, power reads one
// R03 - Writing bit 4 starts port reset
// R04 - Reset end clears active, sets complete flag
// R05 - Reset to disconnected port sets connect change
// R06 - Overcurrent bit follows input, else zero
// R07 - Writing bit 3 resumes only when suspended
// R08 - Writing bit 2 suspends, needs connection
// R09 - Suspend clears on resume, reset, controller resume
// R10 - Hardware disable sets enable-change flag
// R11 - Reset or resume completion sets enabled
// R12 - Enable to disconnected port sets connect change
// R13 - Bit 0 write clears enable only
// R14 - Non-removable device always reads connected; the code reads it disconnected while power is off
// R15 - Bus clock must exceed thirty megahertz
// R16 - Serial engines use 60/48 MHz clocks
// R17 - Reset signalling lasts ten milliseconds
// R18 - Change flags clear on writing one
// R19 - Line inputs synchronised before use
`timescale 1ns/10ps
module urp_port
  import urp_pkg::*;
#(
  parameter int unsigned RST_CYC = RESET_SIG_CYC,  // Reset signalling cycles
  parameter int unsigned RES_CYC = RESUME_CYC      // Resume cycles
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  // Line inputs
  input  wire logic        line_conn,
  input  wire logic        line_ls,
  input  wire logic        line_ovc,
  input  wire logic        line_babble,
  // Port outputs
  output logic             port_power_ff,
  output logic             port_reset_drive_ff,
  output logic             port_resume_drive_ff,
  output logic             irq_ff
);

  if (RST_CYC < 2 || RES_CYC < 2)
  begin : g_bad_counts
    $error("urp_port: counts too small");
  end

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rsync_ff;  // Reset release chain
  logic       rst_n;     // Local reset
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rsync_ff <= 2'h0;
    else
      rsync_ff <= {rsync_ff[0], 1'b1};
  end
  assign rst_n = rsync_ff[1];

  // ==========================================================================
  // Line synchronisation
  // ==========================================================================
  urp_line_s ln;  // Synchronised lines
  // R19 synchronised line inputs
  urp_sync #(.W(4)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d_in    ({line_conn, line_ls, line_ovc, line_babble}),
    .d_out   (ln)
  );

  // ==========================================================================
  // State
  // ==========================================================================
  urp_state_e  st_ff, nxt_st;        // Port state
  logic [31:0] cnt_ff, nxt_cnt;      // Timer
  logic        pwr_ff, nxt_pwr;      // Power status
  logic        ena_ff, nxt_ena;      // Enabled status
  logic [4:0]  chg_ff, nxt_chg;      // Change flags 16..20
  logic [4:0]  msk_ff, nxt_msk;      // Interrupt mask
  logic [2:0]  cfg_ff, nxt_cfg;      // Configuration
  logic        conn_d_ff, ovc_d_ff;  // Previous connect/overcurrent view
  logic        rd_ff, nxt_rd;        // Answer phase
  logic [31:0] rdat_ff, nxt_rdat;    // Read data
  logic [1:0]  resp_ff, nxt_resp;    // Response

  logic        conn_v, ovc_v, pwr_v;  // Visible status
  logic        wr_port, wr_ist, wr_msk, wr_cfg, go;
  logic [31:0] wd;                    // Byte-masked write data
  logic [31:0] port_word;             // Read view

  // Visible status values
  always_comb
  begin
    // R02 power without switching
    pwr_v  = pwr_ff | ~cfg_ff[C_PSW];
    // R14 non-removable connected
    // R01 power loss hides connect
    conn_v = (ln.conn | cfg_ff[C_NRM]) & pwr_v;
    // R06 overcurrent follows input
    ovc_v  = ln.ovc & cfg_ff[C_POC];
  end

  // Bus decode: writes land at the edge where waitrequest is low
  always_comb
  begin
    go      = (avs_read | avs_write) & ~rd_ff;
    wd      = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wr_port = 1'b0;
    wr_ist  = 1'b0;
    wr_msk  = 1'b0;
    wr_cfg  = 1'b0;
    if (rd_ff && avs_write && avs_address == OFS_PORT)
      wr_port = 1'b1;
    else if (rd_ff && avs_write && avs_address == OFS_IST)
      wr_ist = 1'b1;
    else if (rd_ff && avs_write && avs_address == OFS_IMSK)
      wr_msk = 1'b1;
    else if (rd_ff && avs_write && avs_address == OFS_CFG)
      wr_cfg = 1'b1;
  end

  // Read view of the port word
  always_comb
  begin
    port_word         = 32'h0000_0000;
    port_word[B_CONN] = conn_v;
    port_word[B_ENA]  = ena_ff;
    port_word[B_SUSP] = (st_ff == ST_SUSP) || (st_ff == ST_RESUME);
    port_word[B_OVC]  = ovc_v;
    port_word[B_RST]  = (st_ff == ST_RESET);
    port_word[B_PWR]  = pwr_v;
    port_word[B_LS]   = ln.ls & conn_v;
    port_word[20:16]  = chg_ff;
  end

  // Next-state logic of the port
  always_comb
  begin
    logic [4:0] set_c;  // Hardware sets this cycle
    set_c    = 5'h00;
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_pwr  = pwr_ff;
    nxt_ena  = ena_ff;
    nxt_msk  = wr_msk ? wd[4:0] : msk_ff;
    nxt_cfg  = wr_cfg ? wd[2:0] : cfg_ff;
    // Power control
    if (wr_port && wd[B_PWR])
      nxt_pwr = 1'b1;
    if ((wr_port && wd[B_LS]) || ovc_v)
      nxt_pwr = 1'b0;
    // Connect and overcurrent edges
    if (conn_v != conn_d_ff)
      set_c[0] = 1'b1;
    if (ovc_v != ovc_d_ff)
      set_c[3] = 1'b1;
    case (st_ff)
      ST_IDLE:
      begin
        if (wr_port && wd[B_RST])
        begin
          // R05 reset needs connection
          if (!conn_v)
            set_c[0] = 1'b1;
          else
          begin
            // R03 reset signalling starts
            nxt_st  = ST_RESET;
            nxt_cnt = 32'(RST_CYC - 1);
          end
        end
        else if (wr_port && wd[B_SUSP])
        begin
          // R08 suspend needs connection
          if (!conn_v)
            set_c[0] = 1'b1;
          else
            nxt_st = ST_SUSP;
        end
      end
      ST_RESET:
      begin
        // R17 ten millisecond reset
        if (cnt_ff == 32'h0000_0000)
        begin
          // R04 clear active, set complete
          nxt_st   = ST_IDLE;
          set_c[4] = 1'b1;
          // R11 enable on completion
          nxt_ena  = 1'b1;
        end
        else
          nxt_cnt = cnt_ff - 32'h0000_0001;
      end
      ST_SUSP:
      begin
        // R09 controller resume state
        if (wr_cfg && wd[C_URES])
          nxt_st = ST_IDLE;
        // R07 resume only when suspended
        else if (wr_port && wd[B_OVC])
        begin
          nxt_st  = ST_RESUME;
          nxt_cnt = 32'(RES_CYC - 1);
        end
        else if (wr_port && wd[B_RST] && conn_v)
        begin
          nxt_st  = ST_RESET;
          nxt_cnt = 32'(RST_CYC - 1);
        end
      end
      ST_RESUME:
      begin
        if (cnt_ff == 32'h0000_0000)
        begin
          // R09 suspend ends with flag
          nxt_st   = ST_IDLE;
          set_c[2] = 1'b1;
          // R11 enable on resume
          nxt_ena  = 1'b1;
        end
        else
          nxt_cnt = cnt_ff - 32'h0000_0001;
      end
      default:
        nxt_st = ST_IDLE;
    endcase
    // R12 enable needs connection
    if (wr_port && wd[B_ENA])
    begin
      if (!conn_v)
        set_c[0] = 1'b1;
      else
        nxt_ena = 1'b1;
    end
    // R13 bit 0 clears enable only
    if (wr_port && wd[B_CONN])
      nxt_ena = 1'b0;
    // R10 hardware disable flags change
    if (ena_ff && (ovc_v || !conn_v || !pwr_v || ln.bab))
    begin
      nxt_ena  = 1'b0;
      set_c[1] = 1'b1;
    end
    // R01 power loss clears status
    if (!pwr_v)
    begin
      nxt_st  = ST_IDLE;
      nxt_ena = 1'b0;
    end
    // R18 write one clears, set wins
    nxt_chg = (chg_ff & ~((wr_port ? wd[20:16] : 5'h00) | (wr_ist ? wd[4:0] : 5'h00)))
              | set_c;
    // Resume flag drops when reset completes
    if (set_c[4])
      nxt_chg[2] = 1'b0;
  end

  // Bus answer: one wait cycle, then data
  always_comb
  begin
    nxt_rd   = go;
    nxt_rdat = 32'h0000_0000;
    nxt_resp = AV_OKAY;
    if (go && avs_address == OFS_PORT)
      nxt_rdat = port_word;
    else if (go && avs_address == OFS_IST)
      nxt_rdat = {27'h0, chg_ff};
    else if (go && avs_address == OFS_IMSK)
      nxt_rdat = {27'h0, msk_ff};
    else if (go && avs_address == OFS_CFG)
      nxt_rdat = {29'h0, cfg_ff};
    else if (go)
      nxt_resp = AV_DECE;
  end

  // Register all state
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff                <= ST_IDLE;
      cnt_ff               <= 32'h0000_0000;
      pwr_ff               <= 1'b1;
      ena_ff               <= 1'b0;
      chg_ff               <= 5'h00;
      msk_ff               <= RST_IMSK;
      cfg_ff               <= RST_CFG;
      conn_d_ff            <= 1'b0;
      ovc_d_ff             <= 1'b0;
      rd_ff                <= 1'b0;
      rdat_ff              <= 32'h0000_0000;
      resp_ff              <= AV_OKAY;
      port_power_ff        <= 1'b0;
      port_reset_drive_ff  <= 1'b0;
      port_resume_drive_ff <= 1'b0;
      irq_ff               <= 1'b0;
    end
    else
    begin
      st_ff                <= nxt_st;
      cnt_ff               <= nxt_cnt;
      pwr_ff               <= nxt_pwr;
      ena_ff               <= nxt_ena;
      chg_ff               <= nxt_chg;
      msk_ff               <= nxt_msk;
      cfg_ff               <= nxt_cfg;
      conn_d_ff            <= conn_v;
      ovc_d_ff             <= ovc_v;
      rd_ff                <= nxt_rd;
      rdat_ff              <= nxt_rdat;
      resp_ff              <= nxt_resp;
      port_power_ff        <= nxt_pwr | ~nxt_cfg[C_PSW];
      port_reset_drive_ff  <= (nxt_st == ST_RESET);
      port_resume_drive_ff <= (nxt_st == ST_RESUME);
      irq_ff               <= |(nxt_chg & nxt_msk);
    end
  end

  // Wait while request is taken, answer next cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~rd_ff;
  assign avs_readdata    = rdat_ff;
  assign avs_response    = resp_ff;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_reset_done_flag: assert property ( // R04
    @(posedge clk_sys) disable iff (!rst_n)
    (st_ff == ST_RESET && cnt_ff == 0 && pwr_v) |=> (chg_ff[4] && st_ff == ST_IDLE && ena_ff))
    else $error("reset end did not set flag");

  a_reset_no_conn: assert property ( // R05
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_port && wd[B_RST] && !conn_v && st_ff == ST_IDLE) |=> (st_ff != ST_RESET && chg_ff[0]))
    else $error("reset on disconnected port");

  a_reset_starts: assert property ( // R03
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_port && wd[B_RST] && conn_v && st_ff == ST_IDLE && pwr_v) |=> port_reset_drive_ff)
    else $error("reset did not start");

  a_power_off_clear: assert property ( // R01
    @(posedge clk_sys) disable iff (!rst_n)
    (!pwr_v) |=> (!ena_ff && st_ff == ST_IDLE))
    else $error("power loss kept status");

  a_pwr_no_switch: assert property ( // R02
    @(posedge clk_sys) disable iff (!rst_n)
    (!cfg_ff[C_PSW]) |-> port_word[B_PWR])
    else $error("power not one without switching");

  a_resume_gate: assert property ( // R07
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_port && wd[B_OVC] && st_ff == ST_IDLE) |=> !port_resume_drive_ff)
    else $error("resume from non-suspended");

  a_hw_disable: assert property ( // R10
    @(posedge clk_sys) disable iff (!rst_n)
    ($fell(ena_ff) && !$past(wr_port)) |-> chg_ff[1])
    else $error("hardware disable without flag");

  a_nonremovable: assert property ( // R14
    @(posedge clk_sys) disable iff (!rst_n)
    (cfg_ff[C_NRM] && pwr_v) |-> conn_v)
    else $error("non-removable not connected");

  a_irq_level: assert property ( // R18
    @(posedge clk_sys) disable iff (!rst_n)
    irq_ff == |(chg_ff & msk_ff))
    else $error("irq does not match pending flags");

endmodule : urp_port

// *** dv/urp_dev_model.sv ***
// Downstream device model: drives the line inputs of the root port.
// Assumes the bench plugs, unplugs and faults it through the control inputs.
`timescale 1ns/10ps
module urp_dev_model
(
  // Bench controls
  input  wire logic attach,      // Device plugged in
  input  wire logic low_speed,   // Device is low speed
  input  wire logic fault_ovc,   // Supply overcurrent
  input  wire logic babble_go,   // Device babbles on the bus
  // Line outputs
  output logic      line_conn,   // Attach detect
  output logic      line_ls,     // Speed detect
  output logic      line_ovc,    // Overcurrent detect
  output logic      line_babble  // Bus error detect
);
  // ==========================================================================
  // Lines
  // ==========================================================================
  // Unplugged lines fall to their pull-downs, so speed and babble read low
  assign line_conn   = attach;
  assign line_ls     = attach & low_speed;
  // Overcurrent comes from the supply switch, not from the device
  assign line_ovc    = fault_ovc;
  assign line_babble = attach & babble_go;
endmodule : urp_dev_model

// *** dv/urp_port_tb.sv ***
// Self-checking bench for the root port status/control block.
// Assumes the device model on the line side; short reset and resume counts.
`timescale 1ns/10ps
module urp_port_tb;
  import urp_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int unsigned TRST = 20;  // Short reset signalling
  localparam int unsigned TRES = 20;  // Short resume
  typedef struct packed {
    logic [31:0] e;  // Expected value
    logic [31:0] m;  // Bits that matter
    logic [1:0]  r;  // Expected response
  } urp_note_s;
  logic        clk_sys;          // System clock
  logic        resetn;           // Active-low reset
  logic [3:0]  avs_address;      // Bus address
  logic        avs_read;         // Read request
  logic        avs_write;        // Write request
  logic [31:0] avs_writedata;    // Write data
  logic [31:0] avs_readdata;     // Read data
  logic        avs_waitrequest;  // Slave stall
  logic [1:0]  avs_response;     // Response code
  logic        line_conn;        // Attach line
  logic        line_ls;          // Speed line
  logic        line_ovc;         // Overcurrent line
  logic        line_babble;      // Bus error line
  logic        port_power_ff;    // Port power
  logic        port_reset_drive_ff;   // Reset signalling
  logic        port_resume_drive_ff;  // Resume signalling
  logic        irq_ff;           // Interrupt
  logic        attach;           // Model controls
  logic        low_speed;
  logic        fault_ovc;
  logic        babble_go;
  urp_note_s   expq[$];          // Pending read notes
  int          miscompares;      // Mismatch count
  int          checked;          // Comparison count
  int unsigned cmd [3] = '{B_RST, B_ENA, B_SUSP};  // Commands to a bare port

  // ==========================================================================
  // Design and partner
  // ==========================================================================
  urp_port #(.RST_CYC(TRST), .RES_CYC(TRES)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .line_conn(line_conn), .line_ls(line_ls),
    .line_ovc(line_ovc), .line_babble(line_babble), .port_power_ff(port_power_ff),
    .port_reset_drive_ff(port_reset_drive_ff), .port_resume_drive_ff(port_resume_drive_ff),
    .irq_ff(irq_ff));
  urp_dev_model u_dev (
    .attach(attach), .low_speed(low_speed), .fault_ovc(fault_ovc), .babble_go(babble_go),
    .line_conn(line_conn), .line_ls(line_ls), .line_ovc(line_ovc),
    .line_babble(line_babble));

  // ==========================================================================
  // Clock, checks and bus tasks
  // ==========================================================================
  // clock above minimum
  always #4 clk_sys = ~clk_sys;

  function automatic logic [31:0] bt(input int unsigned n);
    bt = 32'h1 << n;
  endfunction : bt

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected word at %0t: got %h exp %h", $time, g, e);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic g, input logic e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected bit at %0t: got %h exp %h", $time, g, e);
    end
  endtask : cmp_bit

  // Read watcher: answer appears at the edge where waitrequest is low
  always @(posedge clk_sys)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expq.size() > 0)
    begin
      urp_note_s n;
      n = expq.pop_front();
      cmp_word(avs_readdata & n.m, n.e & n.m);
      cmp_word({30'h0, avs_response}, {30'h0, n.r});
    end
  end

  // Request held until waitrequest samples low, then one edge passes
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    avs_address   <= a;
    avs_read      <= !w;
    avs_write     <= w;
    avs_writedata <= d;
    if (!w)
      expq.push_back('{e: e, m: m, r: r});
    @(posedge clk_sys iff avs_waitrequest === 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 32'h0, 32'h0, AV_OKAY);
  endtask : wr

  task automatic rp(input logic [31:0] e, input logic [31:0] m);
    bus(OFS_PORT, 1'b0, 32'h0, e, m, AV_OKAY);
  endtask : rp

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog: the sequence needs under two thousand cycles
  initial
  begin
    idle(20000);
    miscompares++;
    tally_and_finish();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    int          n;
    logic [31:0] m;
    clk_sys = 1'b0; resetn = 1'b0; avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; attach = 1'b0; low_speed = 1'b0; fault_ovc = 1'b0;
    babble_go = 1'b0; miscompares = 0; checked = 0;
    void'($urandom(32));
    idle(5);
    resetn <= 1'b1;
    idle(5);
    rp(bt(B_PWR), 32'h001F_011F);
    // Commands to an empty port only flag a connect change
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_PORT, bt(cmd[i]));
      rp(bt(B_CCHG), 32'h0001_001F);
      wr(OFS_PORT, 32'h0);
      rp(bt(B_CCHG), bt(B_CCHG));
      wr(OFS_PORT, bt(B_CCHG));
      rp(32'h0, bt(B_CCHG));
    end
    // Plug in a device of random speed
    low_speed <= 1'($urandom);
    attach    <= 1'b1;
    idle(6);
    rp(bt(B_CONN) | bt(B_CCHG) | ({31'h0, low_speed} << B_LS), 32'h0001_0201);
    wr(OFS_PORT, bt(B_CCHG));
    // Port reset and its length
    wr(OFS_PORT, bt(B_RST));
    rp(bt(B_RST) | bt(B_CONN), bt(B_RST) | bt(B_CONN));
    for (n = 0; n < 100 && port_reset_drive_ff !== 1'b0; n++) @(posedge clk_sys);
    cmp_bit(n + 5 >= TRST - 2 && n + 5 <= TRST + 2, 1'b1);
    rp(bt(B_ENA) | bt(B_RCHG), bt(B_RST) | bt(B_ENA) | bt(B_RCHG));
    wr(OFS_PORT, bt(B_RCHG));
    // Resume refused while not suspended
    wr(OFS_PORT, bt(B_OVC));
    idle(3);
    cmp_bit(port_resume_drive_ff, 1'b0);
    // Suspend then resume
    wr(OFS_PORT, bt(B_SUSP));
    rp(bt(B_SUSP), bt(B_SUSP));
    wr(OFS_PORT, bt(B_OVC));
    cmp_bit(port_resume_drive_ff, 1'b1);
    for (n = 0; n < 100 && port_resume_drive_ff !== 1'b0; n++) @(posedge clk_sys);
    idle(2);
    rp(bt(B_ENA) | bt(B_SCHG), bt(B_SUSP) | bt(B_ENA) | bt(B_SCHG));
    // Controller resume state, then reset, each end suspend
    wr(OFS_PORT, bt(B_SUSP));
    wr(OFS_CFG, {29'h0, RST_CFG} | bt(C_URES));
    rp(32'h0, bt(B_SUSP));
    idle(30);
    wr(OFS_PORT, bt(B_SUSP));
    wr(OFS_PORT, bt(B_RST));
    for (n = 0; n < 100 && port_reset_drive_ff !== 1'b0; n++) @(posedge clk_sys);
    idle(2);
    rp(bt(B_RCHG), bt(B_SUSP) | bt(B_RCHG) | bt(B_SCHG));
    wr(OFS_PORT, 32'h001F_0000);
    // Software disable, then babble
    wr(OFS_PORT, bt(B_CONN));
    rp(bt(B_CONN), bt(B_CONN) | bt(B_ENA) | bt(B_ECHG));
    wr(OFS_PORT, bt(B_ENA));
    babble_go <= 1'b1;
    idle(3);
    babble_go <= 1'b0;
    idle(3);
    rp(bt(B_ECHG), bt(B_ENA) | bt(B_ECHG));
    wr(OFS_PORT, bt(B_ECHG));
    // Mask register and interrupt on a disconnect
    m = $urandom;
    wr(OFS_IMSK, m);
    bus(OFS_IMSK, 1'b0, 32'h0, m, 32'h1F, AV_OKAY);
    wr(OFS_IMSK, 32'h0);
    wr(OFS_PORT, bt(B_ENA));
    attach <= 1'b0;
    idle(6);
    cmp_bit(irq_ff, 1'b0);
    rp(bt(B_ECHG) | bt(B_CCHG), bt(B_CONN) | bt(B_ENA) | bt(B_ECHG) | bt(B_CCHG));
    bus(OFS_IST, 1'b0, 32'h0, 32'h3, 32'h3, AV_OKAY);
    wr(OFS_IMSK, 32'h1);
    idle(2);
    cmp_bit(irq_ff, 1'b1);
    wr(OFS_IST, 32'h1F);
    idle(2);
    cmp_bit(irq_ff, 1'b0);
    // Overcurrent on an enabled port
    attach <= 1'b1;
    idle(6);
    wr(OFS_PORT, bt(B_ENA));
    wr(OFS_PORT, 32'h001F_0000);
    fault_ovc <= 1'b1;
    idle(6);
    rp(bt(B_OVC) | bt(B_ECHG), 32'h0002_011B);
    fault_ovc <= 1'b0;
    idle(4);
    wr(OFS_CFG, 32'h1);
    wr(OFS_PORT, bt(B_PWR));
    fault_ovc <= 1'b1;
    idle(6);
    rp(32'h0, bt(B_OVC));
    fault_ovc <= 1'b0;
    idle(4);
    // Power off clears the port state
    wr(OFS_PORT, bt(B_PWR));
    idle(6);
    wr(OFS_PORT, bt(B_ENA));
    wr(OFS_PORT, bt(B_LS));
    rp(32'h0, 32'h0000_011F);
    cmp_bit(port_power_ff, 1'b0);
    wr(OFS_CFG, 32'h0);
    rp(bt(B_PWR), bt(B_PWR));
    cmp_bit(port_power_ff, 1'b1);
    wr(OFS_CFG, bt(C_NRM));
    attach <= 1'b0;
    idle(6);
    rp(bt(B_CONN), bt(B_CONN));
    bus(4'h2, 1'b0, 32'h0, 32'h0, 32'h0, AV_DECE);
    idle(2);
    tally_and_finish();
  end
endmodule : urp_port_tb
